// ==== wtm_pkg.sv ====
package wtm_pkg;
    // Command codes seen on the management link
    localparam logic [7:0]  CMD_OC_LIM    = 8'h4A;
    localparam logic [7:0]  CMD_OT_LIM    = 8'h51;
    localparam logic [7:0]  CMD_OV_LIM    = 8'h57;
    localparam logic [7:0]  CMD_UV_LIM    = 8'h58;
    localparam logic [7:0]  CMD_STAT_BYTE = 8'h78;
    localparam logic [7:0]  CMD_STAT_WORD = 8'h79;
    localparam logic [7:0]  CMD_FLAG_CLR  = 8'h03;
    // Arbitrary link address
    localparam logic [6:0]  DEV_ADDR      = 7'h40;
    // Limit reset values and writable bits
    localparam logic [15:0] OC_RESET      = 16'h0050;
    localparam logic [15:0] OT_RESET      = 16'h0091;
    localparam logic [15:0] OV_RESET      = 16'h0020;
    localparam logic [15:0] UV_RESET      = 16'h001C;
    localparam logic [15:0] MASK_12       = 16'h0FFF;
    localparam logic [15:0] MASK_8        = 16'h00FF;
    // Warning flag positions
    localparam int          WARN_OC       = 0;
    localparam int          WARN_OT       = 1;
    localparam int          WARN_OV       = 2;
    localparam int          WARN_UV       = 3;
    // Status layout
    localparam int          SB_OT         = 2;
    localparam int          SB_OTHER      = 0;
    localparam int          SW_IOUT       = 14;
    localparam int          SW_VIN        = 13;
    // Byte framing
    localparam logic [3:0]  BIT_LAST      = 4'h7;
    localparam logic [3:0]  ACK_SLOT      = 4'h8;
    // Over-temperature detection deadline
    localparam int          OT_DETECT_MS  = 20;
    localparam int          CLK_KHZ       = 100000;
    localparam int          OT_DETECT_CYC = OT_DETECT_MS * CLK_KHZ;

    typedef struct packed {
        logic [15:0] iout;
        logic [15:0] temp;
        logic [15:0] vin;
    } wtm_meas_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD  = 3'b010,
        ST_WLO  = 3'b011,
        ST_WHI  = 3'b100,
        ST_RD   = 3'b101,
        ST_IGN  = 3'b110
    } wtm_state_type;
endpackage : wtm_pkg

// ==== wtm_warning_monitor.sv ====
`timescale 1ns/1ns
// How it works
// - Current above limit sets flags, asserts alert
// - Current limit 242 mA steps, resets 0x0050
// - Temperature above limit sets flags, asserts alert
// - Temperature limit 1 degC steps, resets 0x0091
// - Temperature warning flagged within 20 ms
// - Input above over-voltage limit sets flags, alert
// - Over-voltage limit 500 mV steps, resets 0x20
// - Input below under-voltage limit sets flags, alert
// - Under-voltage limit 250 mV steps, resets 0x1C
// - Every limit is writable and reads back
// - Flags hold until condition gone and cleared
// - Status word low byte equals status byte
module wtm_warning_monitor #(
    parameter int OT_DETECT_CYC = wtm_pkg::OT_DETECT_CYC
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  link_scl_i,
    input  wire logic                  sda_i,
    output wire logic                  sda_o,
    output wire logic                  sda_oe_n_o,
    input  wire wtm_pkg::wtm_meas_type meas_i,
    input  wire logic                  meas_valid_i,
    output wire logic                  warning_notice_n_o
);
    import wtm_pkg::*;

    function automatic logic [15:0] limit_mask(input logic [7:0] cmd);
        limit_mask = (cmd == CMD_OT_LIM) ? MASK_8 : MASK_12;
    endfunction : limit_mask

    // Link domain: capture each bit on the link clock, announce it by toggle
    logic lk_bit_reg;
    logic lk_tgl_reg;

    always_ff @(posedge link_scl_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lk_bit_reg <= 1'b0;
            lk_tgl_reg <= 1'b0;
        end else begin
            lk_bit_reg <= sda_i;
            lk_tgl_reg <= ~lk_tgl_reg;
        end
    end

    // Synchronisers; stage 3 is only a delayed copy for edge finding
    logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
    logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
            {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
            {tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <= 3'h0;
        end else begin
            {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {link_scl_i, scl_s1_reg, scl_s2_reg};
            {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {sda_i, sda_s1_reg, sda_s2_reg};
            {tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <= {lk_tgl_reg, tgl_s1_reg, tgl_s2_reg};
        end
    end

    logic start_w, stop_w, scl_fall_w, bit_evt_w;
    logic [7:0] rx_byte_w;

    assign start_w    = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
    assign stop_w     = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
    assign scl_fall_w = scl_s3_reg & ~scl_s2_reg;
    // Captured bit is stable for a whole link half period after the toggle lands
    assign bit_evt_w  = tgl_s2_reg ^ tgl_s3_reg;

    // Limits, status and flags
    logic [15:0]  oc_lim_reg, ot_lim_reg, ov_lim_reg, uv_lim_reg;
    logic [3:0]   warn_reg;
    logic [3:0]   cond_w;
    wtm_meas_type meas_reg;
    logic [7:0]   stat_byte_w;
    logic [15:0]  stat_word_w;
    logic [15:0]  rd_word_w;

    // Protocol state
    wtm_state_type state_reg;
    logic [3:0]    cnt_reg;
    logic [7:0]    sh_reg, cmd_reg, lo_reg, tsh_reg;
    logic [15:0]   rdw_reg, wdata_reg;
    logic          ack_reg, tx_reg, rdp_reg, rbyte_reg;
    logic          wr_pulse_reg, clr_pulse_reg;
    logic          oe_n_reg, notice_n_reg;

    assign rx_byte_w = {sh_reg[6:0], lk_bit_reg};

    assign stat_byte_w = {5'h00, warn_reg[WARN_OT], 1'b0,
                          warn_reg[WARN_OC] | warn_reg[WARN_OV] | warn_reg[WARN_UV]};
    assign stat_word_w = {1'b0, warn_reg[WARN_OC], warn_reg[WARN_OV] | warn_reg[WARN_UV],
                          5'h00, stat_byte_w};

    always_comb begin
        if (cmd_reg == CMD_OC_LIM) begin
            rd_word_w = oc_lim_reg;
        end else if (cmd_reg == CMD_OT_LIM) begin
            rd_word_w = ot_lim_reg;
        end else if (cmd_reg == CMD_OV_LIM) begin
            rd_word_w = ov_lim_reg;
        end else if (cmd_reg == CMD_UV_LIM) begin
            rd_word_w = uv_lim_reg;
        end else if (cmd_reg == CMD_STAT_BYTE) begin
            rd_word_w = {8'h00, stat_byte_w};
        end else if (cmd_reg == CMD_STAT_WORD) begin
            rd_word_w = stat_word_w;
        end else begin
            rd_word_w = 16'h0000;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            sh_reg        <= 8'h00;
            cmd_reg       <= 8'h00;
            lo_reg        <= 8'h00;
            tsh_reg       <= 8'h00;
            rdw_reg       <= 16'h0000;
            wdata_reg     <= 16'h0000;
            ack_reg       <= 1'b0;
            tx_reg        <= 1'b0;
            rdp_reg       <= 1'b0;
            rbyte_reg     <= 1'b0;
            wr_pulse_reg  <= 1'b0;
            clr_pulse_reg <= 1'b0;
        end else begin
            wr_pulse_reg  <= 1'b0;
            clr_pulse_reg <= 1'b0;
            if (start_w) begin
                state_reg <= ST_ADDR;
                cnt_reg   <= 4'h0;
                tx_reg    <= 1'b0;
                rdp_reg   <= 1'b0;
                ack_reg   <= 1'b0;
            end else if (stop_w) begin
                state_reg <= ST_IDLE;
                tx_reg    <= 1'b0;
                ack_reg   <= 1'b0;
            end else if (bit_evt_w && state_reg != ST_IDLE) begin
                if (cnt_reg == ACK_SLOT) begin
                    cnt_reg <= 4'h0;
                    ack_reg <= 1'b0;
                    if (tx_reg) begin
                        // High level in the acknowledge slot ends a read
                        if (lk_bit_reg) begin
                            tx_reg    <= 1'b0;
                            state_reg <= ST_IGN;
                        end else begin
                            tsh_reg   <= rbyte_reg ? 8'h00 : rdw_reg[15:8];
                            rbyte_reg <= 1'b1;
                        end
                    end else if (rdp_reg) begin
                        tx_reg  <= 1'b1;
                        rdp_reg <= 1'b0;
                    end
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                    sh_reg  <= rx_byte_w;
                    if (cnt_reg == BIT_LAST && !tx_reg) begin
                        case (state_reg)
                            ST_ADDR: begin
                                if (rx_byte_w[7:1] == DEV_ADDR) begin
                                    ack_reg <= 1'b1;
                                    if (rx_byte_w[0]) begin
                                        rdp_reg   <= 1'b1;
                                        rdw_reg   <= rd_word_w;
                                        tsh_reg   <= rd_word_w[7:0];
                                        rbyte_reg <= 1'b0;
                                        state_reg <= ST_RD;
                                    end else begin
                                        state_reg <= ST_CMD;
                                    end
                                end else begin
                                    state_reg <= ST_IGN;
                                end
                            end
                            ST_CMD: begin
                                ack_reg       <= 1'b1;
                                cmd_reg       <= rx_byte_w;
                                clr_pulse_reg <= (rx_byte_w == CMD_FLAG_CLR);
                                state_reg     <= ST_WLO;
                            end
                            ST_WLO: begin
                                ack_reg   <= 1'b1;
                                lo_reg    <= rx_byte_w;
                                state_reg <= ST_WHI;
                            end
                            ST_WHI: begin
                                ack_reg      <= 1'b1;
                                wdata_reg    <= {rx_byte_w, lo_reg};
                                wr_pulse_reg <= 1'b1;
                                state_reg    <= ST_IGN;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        end
    end

    // Data line changes after a clock fall, or is released at a start or stop while the clock is high; a logic 1 means release
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_n_reg <= 1'b1;
        end else if (start_w || stop_w) begin
            oe_n_reg <= 1'b1;
        end else if (scl_fall_w) begin
            if (cnt_reg == ACK_SLOT) begin
                oe_n_reg <= ~ack_reg;
            end else if (tx_reg) begin
                oe_n_reg <= tsh_reg[3'(BIT_LAST - cnt_reg)];
            end else begin
                oe_n_reg <= 1'b1;
            end
        end
    end

    assign sda_o      = 1'b0;
    assign sda_oe_n_o = oe_n_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oc_lim_reg <= OC_RESET;
            ot_lim_reg <= OT_RESET;
            ov_lim_reg <= OV_RESET;
            uv_lim_reg <= UV_RESET;
        end else if (wr_pulse_reg) begin
            if (cmd_reg == CMD_OC_LIM) begin
                oc_lim_reg <= wdata_reg & limit_mask(cmd_reg);
            end else if (cmd_reg == CMD_OT_LIM) begin
                ot_lim_reg <= wdata_reg & limit_mask(cmd_reg);
            end else if (cmd_reg == CMD_OV_LIM) begin
                ov_lim_reg <= wdata_reg & limit_mask(cmd_reg);
            end else if (cmd_reg == CMD_UV_LIM) begin
                uv_lim_reg <= wdata_reg & limit_mask(cmd_reg);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meas_reg <= '0;
        end else if (meas_valid_i) begin
            meas_reg <= meas_i;
        end
    end

    // Input voltage arrives in 250 mV steps, so the 500 mV limit is doubled
    assign cond_w[WARN_OC] = meas_reg.iout > oc_lim_reg;
    assign cond_w[WARN_OT] = meas_reg.temp > ot_lim_reg;
    assign cond_w[WARN_OV] = {1'b0, meas_reg.vin} > {ov_lim_reg, 1'b0};
    assign cond_w[WARN_UV] = meas_reg.vin < uv_lim_reg;

    // A live condition keeps its flag set, so a clear cannot lose it
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warn_reg <= 4'h0;
        end else begin
            warn_reg <= cond_w | (warn_reg & ~{4{clr_pulse_reg}});
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            notice_n_reg <= 1'b1;
        end else begin
            notice_n_reg <= ~|warn_reg;
        end
    end

    assign warning_notice_n_o = notice_n_reg;

    // Checks
    logic        init_reg;
    logic [31:0] ot_wait_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            init_reg    <= 1'b1;
            ot_wait_reg <= 32'h0000_0000;
        end else begin
            init_reg    <= 1'b0;
            ot_wait_reg <= (cond_w[WARN_OT] && !warn_reg[WARN_OT]) ? ot_wait_reg + 32'h0000_0001
                                                                   : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_oc_cross;
        meas_reg.iout > oc_lim_reg;
    endsequence
    sequence s_notice_on;
        ##1 warn_reg[WARN_OC] ##1 !warning_notice_n_o;
    endsequence

    oc_flag_alert_a: assert property (s_oc_cross |-> s_notice_on)
        else $error("current warning did not raise flag and alert");
    oc_reset_val_a: assert property (init_reg |-> oc_lim_reg == 16'h0050)
        else $error("current limit reset value wrong");
    ot_flag_byte_a: assert property (cond_w[WARN_OT] |=> stat_byte_w[SB_OT] && stat_word_w[SB_OT])
        else $error("temperature warning missing in status");
    ot_reset_val_a: assert property (init_reg |-> ot_lim_reg == 16'h0091)
        else $error("temperature limit reset value wrong");
    ot_detect_time_a: assert property (ot_wait_reg < 32'(OT_DETECT_CYC))
        else $error("temperature warning too slow");
    ov_flag_set_a: assert property ({1'b0, meas_reg.vin} > {ov_lim_reg, 1'b0}
                                    |=> warn_reg[WARN_OV] && stat_word_w[SW_VIN])
        else $error("over-voltage warning not flagged");
    ov_reset_val_a: assert property (init_reg |-> ov_lim_reg == 16'h0020)
        else $error("over-voltage limit reset value wrong");
    uv_flag_alert_a: assert property (meas_reg.vin < uv_lim_reg
                                      |=> warn_reg[WARN_UV] ##1 !warning_notice_n_o)
        else $error("under-voltage warning not flagged");
    uv_reset_val_a: assert property (init_reg |-> uv_lim_reg == 16'h001C)
        else $error("under-voltage limit reset value wrong");
    limit_write_a: assert property (wr_pulse_reg && cmd_reg == CMD_OC_LIM
                                    |=> oc_lim_reg == ($past(wdata_reg) & 16'h0FFF))
        else $error("limit write not stored");
    flag_hold_a: assert property (!clr_pulse_reg |=> ($past(warn_reg) & ~warn_reg) == 4'h0)
        else $error("flag dropped without clear");
    word_low_byte_a: assert property (rd_word_w == stat_word_w && cmd_reg == CMD_STAT_WORD
                                      |-> rd_word_w[7:0] == stat_byte_w)
        else $error("status word low byte mismatch");
    strict_compare_a: assert property (meas_reg.iout == oc_lim_reg && !warn_reg[WARN_OC]
                                       |=> !warn_reg[WARN_OC])
        else $error("equal current raised a warning");

endmodule : wtm_warning_monitor

// ==== wtm_host_model.sv ====
`timescale 1ns/1ns
module wtm_host_model (
    output logic      scl_o,
    output logic      sda_oe_n_o,
    input  wire logic sda_i
);
    import wtm_pkg::*;

    // Link clock idles high and only toggles inside frames
    initial begin
        scl_o      = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    // Data changes mid-low, is sampled just after the rise
    task automatic put_bit(input logic b, output logic r);
        sda_oe_n_o = b;
        #20 scl_o = 1'b1;
        #1 r = sda_i;
        #39 scl_o = 1'b0;
        #20;
    endtask : put_bit

    task automatic start_cond();
        sda_oe_n_o = 1'b1;
        #20 scl_o = 1'b1;
        #40 sda_oe_n_o = 1'b0;
        #40 scl_o = 1'b0;
        #20;
    endtask : start_cond

    task automatic stop_cond();
        sda_oe_n_o = 1'b0;
        #20 scl_o = 1'b1;
        #40 sda_oe_n_o = 1'b1;
        #40;
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] d, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i], a);
        put_bit(1'b1, a);
        ok = ok & ~a;
    endtask : send_byte

    // Last byte of a read is refused so the device lets go of the line
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(last, a);
    endtask : get_byte

    // Zero data bytes makes a bare command, two bytes a word, low first
    task automatic write_cmd(input logic [6:0] addr, input logic [7:0] cmd, input int n,
                             input logic [15:0] data, output logic ok);
        ok = 1'b1;
        start_cond();
        send_byte({addr, 1'b0}, ok);
        send_byte(cmd, ok);
        if (n > 0) begin
            send_byte(data[7:0], ok);
            send_byte(data[15:8], ok);
        end
        stop_cond();
    endtask : write_cmd

    task automatic read_cmd(input logic [6:0] addr, input logic [7:0] cmd, input int n,
                            output logic [15:0] data, output logic ok);
        logic [7:0] b;
        ok   = 1'b1;
        data = 16'h0000;
        start_cond();
        send_byte({addr, 1'b0}, ok);
        send_byte(cmd, ok);
        start_cond();
        send_byte({addr, 1'b1}, ok);
        for (int k = 0; k < n; k++) begin
            get_byte(k == n - 1, b);
            data[8*k +: 8] = b;
        end
        stop_cond();
    endtask : read_cmd
endmodule : wtm_host_model

// ==== test_warning_threshold_monitor.sv ====
`timescale 1ns/1ns
module test_warning_threshold_monitor;
    import wtm_pkg::*;
    logic         mclk_i;
    logic         rstn_i;
    logic         meas_valid_i;
    wtm_meas_type meas_i;
    logic         scl;
    logic         host_oe_n;
    wire logic    sda_o;
    wire logic    sda_oe_n_o;
    wire logic    warning_notice_n_o;
    wire logic    sda_wire;
    int           bad_count;
    int           tests_run;

    // Pulled-up open-drain line shared by host and device
    assign sda_wire = host_oe_n & (sda_oe_n_o | sda_o);

    wtm_warning_monitor #(.OT_DETECT_CYC(16)) uut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .link_scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .meas_i(meas_i), .meas_valid_i(meas_valid_i),
        .warning_notice_n_o(warning_notice_n_o));
    wtm_host_model host (.scl_o(scl), .sda_oe_n_o(host_oe_n), .sda_i(sda_wire));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
        logic ok;
        host.write_cmd(DEV_ADDR, cmd, n, d, ok);
        chk("write ack", 16'h0001, {15'h0000, ok});
    endtask : wr

    task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d);
        logic ok;
        host.read_cmd(DEV_ADDR, cmd, n, d, ok);
        chk("read ack", 16'h0001, {15'h0000, ok});
    endtask : rd

    task automatic put_meas(input wtm_meas_type m);
        @(posedge mclk_i);
        #1 meas_i = m;
        meas_valid_i = 1'b1;
        @(posedge mclk_i);
        #1 meas_valid_i = 1'b0;
    endtask : put_meas

    // Bounded wait for the alert to reach a level
    task automatic wait_alert(input logic lvl);
        int n;
        for (n = 0; n < 40 && warning_notice_n_o !== lvl; n++) begin
            @(posedge mclk_i);
            #1;
        end
        chk("alert level", {15'h0000, lvl}, {15'h0000, warning_notice_n_o});
        // A wait that ran out has been counted and ends the run
        if (warning_notice_n_o !== lvl) begin
            complete_run();
        end
    endtask : wait_alert

    task automatic t_defaults();
        logic [15:0] d;
        chk("data drive level", 16'h0000, {15'h0000, sda_o});
        chk("data released", 16'h0001, {15'h0000, sda_oe_n_o});
        rd(CMD_OC_LIM, 2, d);
        chk("oc default", 16'h0050, d);
        rd(CMD_OT_LIM, 2, d);
        chk("ot default", 16'h0091, d);
        rd(CMD_OV_LIM, 2, d);
        chk("ov default", 16'h0020, d);
        rd(CMD_UV_LIM, 2, d);
        chk("uv default", 16'h001C, d);
        // Stored input of zero sits under the limit from the first cycle
        rd(CMD_STAT_WORD, 2, d);
        chk("word after reset", 16'h2001, d);
        put_meas(48'h0010_0019_0030);
        chk("alert held", 16'h0000, {15'h0000, warning_notice_n_o});
        wr(CMD_FLAG_CLR, 0, 16'h0000);
        wait_alert(1'b1);
        $display("Test defaults finished");
    endtask : t_defaults

    task automatic t_limits();
        logic [15:0] d;
        logic        ok;
        wr(CMD_OC_LIM, 2, 16'hF123);
        rd(CMD_OC_LIM, 2, d);
        chk("oc readback", 16'h0123, d);
        wr(CMD_OT_LIM, 2, 16'h0096);
        rd(CMD_OT_LIM, 2, d);
        chk("ot readback", 16'h0096, d);
        wr(CMD_OV_LIM, 2, 16'h001E);
        rd(CMD_OV_LIM, 2, d);
        chk("ov readback", 16'h001E, d);
        wr(CMD_UV_LIM, 2, 16'h001D);
        rd(CMD_UV_LIM, 2, d);
        chk("uv readback", 16'h001D, d);
        rd(8'h21, 2, d);
        chk("unknown cmd", 16'h0000, d);
        // Foreign address must be ignored entirely
        host.write_cmd(DEV_ADDR + 7'h01, CMD_OC_LIM, 2, 16'h0001, ok);
        chk("foreign ack", 16'h0000, {15'h0000, ok});
        rd(CMD_OC_LIM, 2, d);
        chk("oc untouched", 16'h0123, d);
        $display("Test limits finished");
    endtask : t_limits

    task automatic t_crossings();
        wtm_meas_type at_m [4]  = '{48'h0123_0050_0030, 48'h0100_0096_0030,
                                    48'h0100_0050_003C, 48'h0100_0050_001D};
        wtm_meas_type over [4]  = '{48'h0124_0050_0030, 48'h0100_0097_0030,
                                    48'h0100_0050_003D, 48'h0100_0050_001C};
        logic [15:0]  wexp [4]  = '{16'h4001, 16'h0004, 16'h2001, 16'h2001};
        logic [15:0]  w;
        logic [15:0]  b;
        for (int k = 0; k < 4; k++) begin
            put_meas(at_m[k]);
            repeat (2) @(posedge mclk_i);
            #1 chk("alert at limit", 16'h0001, {15'h0000, warning_notice_n_o});
            put_meas(over[k]);
            chk("alert one cycle", 16'h0001, {15'h0000, warning_notice_n_o});
            // Flag lands one edge after capture, the alert one edge later
            @(posedge mclk_i);
            #1 chk("alert flag cycle", 16'h0001, {15'h0000, warning_notice_n_o});
            @(posedge mclk_i);
            #1 chk("alert two cycles", 16'h0000, {15'h0000, warning_notice_n_o});
            rd(CMD_STAT_WORD, 2, w);
            chk("status word", wexp[k], w);
            rd(CMD_STAT_BYTE, 1, b);
            chk("status byte", {8'h00, wexp[k][7:0]}, b);
            // Clearing while the condition is still present has no effect
            wr(CMD_FLAG_CLR, 0, 16'h0000);
            rd(CMD_STAT_WORD, 2, w);
            chk("word kept", wexp[k], w);
            put_meas(48'h0100_0050_0030);
            chk("alert still low", 16'h0000, {15'h0000, warning_notice_n_o});
            wr(CMD_FLAG_CLR, 0, 16'h0000);
            wait_alert(1'b1);
            rd(CMD_STAT_WORD, 2, w);
            chk("word cleared", 16'h0000, w);
        end
        $display("Test crossings finished");
    endtask : t_crossings

    initial begin
        bad_count    = 0;
        tests_run    = 0;
        rstn_i       = 1'b0;
        meas_valid_i = 1'b0;
        meas_i       = 48'h0000_0000_0000;
        repeat (16) @(posedge mclk_i);
        #1 rstn_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        t_defaults();
        t_limits();
        t_crossings();
        complete_run();
    end

    initial begin
        #400_000;
        bad_count++;
        $display("Error watchdog expected finish seen hang");
        complete_run();
    end
endmodule : test_warning_threshold_monitor
